// file: include/ptbd_pkg.sv
// Purpose: shared constants for the periodic timebase divider
// Assumes: single 40 MHz clock domain, 8-bit control register
// Notes:   register map and field positions live here
package ptbd_pkg;
  // ********************************************************
  // chain and register map
  // ********************************************************
  localparam int unsigned CHAIN_STAGES = 18;
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_MASK     = 4'h2;
  localparam logic [3:0] ADDR_CONFIG   = 4'h3;
  // control register field positions
  localparam int unsigned BIT_PENDING  = 7;
  localparam int unsigned BIT_RATE_HI  = 6;
  localparam int unsigned BIT_RATE_LO  = 4;
  localparam int unsigned BIT_ACK      = 3;
  localparam int unsigned BIT_IRQ_EN   = 2;
  localparam int unsigned BIT_ENABLE   = 1;
  // config register: bit 0 oscillator keeps running in stop
  localparam int unsigned BIT_STOP_KEEP = 0;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;
  // status register: bit 0 overflow event
  localparam int unsigned BIT_EV_OVF   = 0;
endpackage

// file: rtl/ptbd_chain.sv
// Purpose: binary divider chain with enable and hold-at-zero
// Assumes: clocked by the system clock, advanced by a tick
// Notes:   counter value is the chain state
`timescale 1ns/1ps
module ptbd_chain
  import ptbd_pkg::*;
#(
  parameter int unsigned WIDTH = CHAIN_STAGES
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic             run_in,
  input  wire logic             clear_in,
  output      logic [WIDTH-1:0] count_out
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  // clear wins so a disabled chain stays at zero
  assign count_next = clear_in ? '0 : (run_in ? count_reg + 1'b1 : count_reg);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign count_out = count_reg;
endmodule

// file: rtl/ptbd_tap.sv
// Purpose: selects a tap of the divider chain and detects its rise
// Assumes: chain advances by at most one per cycle
// Notes:   rise of tap bit k marks an overflow of period 2^(k+1)
`timescale 1ns/1ps
module ptbd_tap
  import ptbd_pkg::*;
#(
  parameter int unsigned WIDTH = CHAIN_STAGES
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic             ce_in,
  input  wire logic [2:0]       rate_in,
  input  wire logic [WIDTH-1:0] count_in,
  output      logic             ovf_out
);
  logic tap_bit;
  logic tap_reg;
  // bit index of the tap: ratio 2^(k+1)
  assign tap_bit = (rate_in == 3'h0) ? count_in[17] :
                   (rate_in == 3'h1) ? count_in[16] :
                   (rate_in == 3'h2) ? count_in[15] :
                   (rate_in == 3'h3) ? count_in[14] :
                   (rate_in == 3'h4) ? count_in[5]  :
                   (rate_in == 3'h5) ? count_in[4]  :
                   (rate_in == 3'h6) ? count_in[3]  : count_in[2];
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tap_reg <= 1'b0;
    end else if (ce_in) begin
      tap_reg <= tap_bit;
    end
  end
  // rising edge: first one after half a period, then every period;
  // a stale tap_reg from before a disable cannot fake an edge from a zeroed chain
  assign ovf_out = ce_in & tap_bit & ~tap_reg;
endmodule

// file: rtl/ptbd_top.sv
// Purpose: periodic timebase divider with control, status, mask and config registers
// Assumes: register port with one-cycle read latency, 40 MHz clock
// Notes:   wait and stop levels come from the power controller
`timescale 1ns/1ps
module ptbd_top
  import ptbd_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       SRST_IN,
  input  wire logic       CE_IN,
  input  wire logic       WAIT_MODE_IN,
  input  wire logic       STOP_MODE_IN,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output      logic [7:0] RDATA_OUT,
  output      logic       IRQ_OUT,
  output      logic       WAKE_OUT
);
  // ********************************************************
  // synchronised mode levels
  // ********************************************************
  logic wait_s1_reg;
  logic wait_s2_reg;
  logic stop_s1_reg;
  logic stop_s2_reg;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wait_s1_reg <= 1'b0;
      wait_s2_reg <= 1'b0;
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
    end else if (CE_IN) begin
      wait_s1_reg <= WAIT_MODE_IN;
      wait_s2_reg <= wait_s1_reg;
      stop_s1_reg <= STOP_MODE_IN;
      stop_s2_reg <= stop_s1_reg;
    end
  end

  // ********************************************************
  // register state
  // ********************************************************
  logic       enable_reg;
  logic       irq_en_reg;
  logic [2:0] rate_reg;
  logic       pending_reg;
  logic       stop_keep_reg;
  logic [7:0] mask_reg;
  logic [7:0] status_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic       wake_reg;

  // ********************************************************
  // bus decode
  // ********************************************************
  wire bus_ok   = CE_IN & ~wait_s2_reg & ~stop_s2_reg;
  wire wr_ok    = WR_IN & bus_ok;
  wire rd_ok    = RD_IN & bus_ok;
  wire wr_ctrl  = wr_ok & (ADDR_IN == ADDR_CTRL);
  wire wr_stat  = wr_ok & (ADDR_IN == ADDR_STATUS);
  wire wr_mask  = wr_ok & (ADDR_IN == ADDR_MASK);
  wire wr_cfg   = wr_ok & (ADDR_IN == ADDR_CONFIG);
  wire ack_hit  = wr_ctrl & WDATA_IN[BIT_ACK];

  // ********************************************************
  // divider chain and tap
  // ********************************************************
  logic [CHAIN_STAGES-1:0] count;
  logic                    ovf;
  // stop halts the oscillator unless it was told to keep running
  wire osc_runs  = ~stop_s2_reg | stop_keep_reg;
  wire chain_run = CE_IN & enable_reg & osc_runs;
  wire chain_clr = CE_IN & ~enable_reg;

  ptbd_chain #(
    .WIDTH     (CHAIN_STAGES)
  ) u_chain (
    .clk_in    (CLK_IN),
    .srst_in   (SRST_IN),
    .run_in    (chain_run),
    .clear_in  (chain_clr),
    .count_out (count)
  );

  ptbd_tap #(
    .WIDTH     (CHAIN_STAGES)
  ) u_tap (
    .clk_in    (CLK_IN),
    .srst_in   (SRST_IN),
    .ce_in     (chain_run),
    .rate_in   (rate_reg),
    .count_in  (count),
    .ovf_out   (ovf)
  );

  // ********************************************************
  // next values
  // ********************************************************
  // overflow beats a same-cycle acknowledge so no event is lost
  wire       pending_next = ovf | (pending_reg & ~ack_hit);
  wire [7:0] status_set   = {7'h00, ovf};
  wire [7:0] status_next  = status_set | (status_reg & ~(wr_stat ? WDATA_IN : 8'h00));
  wire [2:0] rate_next    = wr_ctrl ? WDATA_IN[BIT_RATE_HI:BIT_RATE_LO] : rate_reg;
  wire       irq_next     = (pending_next & irq_en_reg) | (|(status_next & mask_reg));
  wire       wake_next    = ovf & stop_s2_reg & irq_en_reg;

  wire [7:0] ctrl_view = {pending_reg, rate_reg, 1'b0, irq_en_reg, enable_reg, 1'b0};
  wire [7:0] cfg_view  = {7'h00, stop_keep_reg};
  wire [7:0] rd_mux    = (ADDR_IN == ADDR_CTRL)   ? ctrl_view  :
                         (ADDR_IN == ADDR_STATUS) ? status_reg :
                         (ADDR_IN == ADDR_MASK)   ? mask_reg   :
                         (ADDR_IN == ADDR_CONFIG) ? cfg_view   : READ_ZERO;
  wire [7:0] rdata_next = rd_ok ? rd_mux : READ_ZERO;

  // ********************************************************
  // control register
  // ********************************************************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      enable_reg <= CTRL_RESET[BIT_ENABLE];
      irq_en_reg <= CTRL_RESET[BIT_IRQ_EN];
      rate_reg   <= CTRL_RESET[BIT_RATE_HI:BIT_RATE_LO];
    end else if (wr_ctrl) begin
      enable_reg <= WDATA_IN[BIT_ENABLE];
      irq_en_reg <= WDATA_IN[BIT_IRQ_EN];
      rate_reg   <= rate_next;
    end
  end

  // pending ignores the written value of its own bit position
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pending_reg <= CTRL_RESET[BIT_PENDING];
    end else if (CE_IN) begin
      pending_reg <= pending_next;
    end
  end

  // ********************************************************
  // interrupt status, mask, config
  // ********************************************************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      status_reg    <= 8'h00;
      mask_reg      <= MASK_RESET;
      stop_keep_reg <= CONFIG_RESET[BIT_STOP_KEEP];
    end else if (CE_IN) begin
      status_reg <= status_next;
      if (wr_mask) begin
        mask_reg <= WDATA_IN;
      end
      if (wr_cfg) begin
        stop_keep_reg <= WDATA_IN[BIT_STOP_KEEP];
      end
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rdata_reg <= READ_ZERO;
      irq_reg   <= 1'b0;
      wake_reg  <= 1'b0;
    end else if (CE_IN) begin
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
      wake_reg  <= wake_next;
    end
  end

  assign RDATA_OUT = rdata_reg;
  assign IRQ_OUT   = irq_reg;
  assign WAKE_OUT  = wake_reg;
endmodule

// file: verification/ptbd_monitor.sv
// Purpose: port checks for ptbd_top
// Assumes: one clock, mode inputs settle within three cycles
// Notes:   bound to every ptbd_top instance
`timescale 1ns/1ps
module ptbd_monitor
  import ptbd_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       SRST_IN,
  input wire logic       CE_IN,
  input wire logic       WAIT_MODE_IN,
  input wire logic       STOP_MODE_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       IRQ_OUT,
  input wire logic       WAKE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_ctrl_wr;
    WR_IN && CE_IN && ADDR_IN == ADDR_CTRL && !WAIT_MODE_IN && !STOP_MODE_IN;
  endsequence
  sequence s_ctrl_rd;
    RD_IN && CE_IN && ADDR_IN == ADDR_CTRL && !WAIT_MODE_IN && !STOP_MODE_IN;
  endsequence
  a_ack_reads_zero: assert property (s_ctrl_rd |=> RDATA_OUT[BIT_ACK] == 1'b0)
    else $error("ack bit read as one");
  a_ctrl_read_back: assert property (s_ctrl_wr ##1 s_ctrl_rd |=> (RDATA_OUT & 8'h76) == ($past(WDATA_IN, 2) & 8'h76))
    else $error("control fields not kept");
  a_irq_holds: assert property (IRQ_OUT && CE_IN && !WR_IN && !$past(WR_IN) |=> IRQ_OUT)
    else $error("request dropped without a write");
  a_reset_quiet: assert property ($fell(SRST_IN) |-> !IRQ_OUT && !WAKE_OUT && RDATA_OUT == 8'h00)
    else $error("output active after reset");
  a_wake_pulse: assert property (WAKE_OUT |=> !WAKE_OUT)
    else $error("wake longer than one cycle");
  a_wake_in_stop: assert property (!STOP_MODE_IN [*5] |=> !WAKE_OUT)
    else $error("wake outside stop");
  a_wait_refused: assert property (RD_IN && WAIT_MODE_IN && $past(WAIT_MODE_IN) && $past(WAIT_MODE_IN, 2)
    |=> RDATA_OUT == 8'h00) else $error("read served in wait");
  a_stop_refused: assert property (RD_IN && STOP_MODE_IN && $past(STOP_MODE_IN) && $past(STOP_MODE_IN, 2)
    |=> RDATA_OUT == 8'h00) else $error("read served in stop");
endmodule
bind ptbd_top ptbd_monitor u_mon (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CE_IN(CE_IN), .WAIT_MODE_IN(WAIT_MODE_IN),
  .STOP_MODE_IN(STOP_MODE_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT), .WAKE_OUT(WAKE_OUT));

// file: verification/ptbd_top_test.sv
// Purpose: self-checking bench for ptbd_top
// Assumes: CE_IN high except in the frozen-write check
// Notes:   only the four fast rates are timed, slow ones cost too many cycles
`timescale 1ns/1ps
module ptbd_top_test
  import ptbd_pkg::*;
;
  logic       clk = 0, srst = 1, ce = 1, wt = 0, stp = 0, wr = 0, rd = 0, irq, wake;
  logic [3:0] adr = '0;
  logic [7:0] wd = '0, rdata;
  int         error_cnt = 0, checks_done = 0, n, p;
  ptbd_top dut (.CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .WAIT_MODE_IN(wt), .STOP_MODE_IN(stp), .ADDR_IN(adr),
    .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .WAKE_OUT(wake));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // a spare cycle after each strobe keeps one assignment per signal per step
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  // read data stand in the cycle after the strobe; taken at the edge ending it
  task automatic rd_chk(input string s, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd <= 1;
    adr <= a;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    chk(s, e, rdata & m);
  endtask
  task automatic wr_rd(input string s, input logic [3:0] a, input logic [7:0] d,
                       input logic [7:0] m, input logic [7:0] e);
    wr <= 1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    chk(s, e, rdata & m);
  endtask
  // irq is registered: look one edge later at the value that stood
  task automatic irq_chk(input logic e);
    @(posedge clk);
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask
  task automatic wait_hi(input bit w);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((w ? wake : irq) !== 1'b1 && n < 400);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_reset;
    for (int a = 0; a < 5; a++) rd_chk("reset", (a == 4) ? 4'hF : 4'(a), 8'hFF, 8'h00);
    irq_chk(1'b0);
    $display("reset done");
  endtask
  task automatic t_rates;
    for (int r = 4; r < 8; r++) begin
      p = 8 << (7 - r);
      wr_reg(ADDR_CTRL, {1'b0, 3'(r), 4'h6});
      wait_hi(0);
      chk("first", 8'h01, {7'h0, n >= p / 2 - 2 && n <= p / 2 + 3});
      wr_reg(ADDR_CTRL, {1'b0, 3'(r), 4'hE});
      wait_hi(0);
      chk("period", p[7:0], 8'(n + 2));
      wr_reg(ADDR_CTRL, 8'h08);
    end
    $display("rates done");
  endtask
  task automatic t_ack;
    wr_reg(ADDR_CTRL, 8'h76);
    wait_hi(0);
    wr_reg(ADDR_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    rd_chk("held", ADDR_CTRL, 8'hFE, 8'h84);
    irq_chk(1'b1);
    wr_reg(ADDR_CTRL, 8'h00);
    irq_chk(1'b0);
    wr_reg(ADDR_CTRL, 8'h8C);
    rd_chk("acked", ADDR_CTRL, 8'h8C, 8'h04);
    rd_chk("event", ADDR_STATUS, 8'h01, 8'h01);
    wr_reg(ADDR_MASK, 8'h01);
    irq_chk(1'b1);
    wr_reg(ADDR_STATUS, 8'h01);
    rd_chk("event", ADDR_STATUS, 8'h01, 8'h00);
    irq_chk(1'b0);
    wr_reg(ADDR_MASK, 8'h00);
    wr_rd("back to back", ADDR_CTRL, 8'h54, 8'h76, 8'h54);
    ce <= 0;
    wr_reg(ADDR_CTRL, 8'h76);
    ce <= 1;
    rd_chk("frozen", ADDR_CTRL, 8'h76, 8'h54);
    wr_reg(ADDR_CTRL, 8'h00);
    $display("ack done");
  endtask
  task automatic t_modes;
    wr_reg(ADDR_CTRL, 8'h76);
    wt <= 1;
    repeat (4) @(posedge clk);
    wr_reg(ADDR_CTRL, 8'h00);
    rd_chk("wait read", ADDR_CTRL, 8'hFF, 8'h00);
    wait_hi(0);
    irq_chk(1'b1);
    wt <= 0;
    repeat (4) @(posedge clk);
    rd_chk("ctrl", ADDR_CTRL, 8'h76, 8'h76);
    wr_reg(ADDR_CTRL, 8'h08);
    for (int k = 0; k < 2; k++) begin
      wr_reg(ADDR_CONFIG, 8'(k));
      wr_reg(ADDR_CTRL, 8'h46);
      stp <= 1;
      wait_hi(1);
      chk("wake", 8'(k), {7'h0, n < 400});
      rd_chk("stop read", ADDR_CTRL, 8'hFF, 8'h00);
      stp <= 0;
      repeat (4) @(posedge clk);
      rd_chk("pending", ADDR_CTRL, 8'h80, {k[0], 7'h0});
      wr_reg(ADDR_CTRL, 8'h08);
    end
    $display("modes done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    t_reset();
    t_rates();
    t_ack();
    t_modes();
    wr_reg(ADDR_CTRL, 8'h76);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    t_reset();
    finish_test();
  end
endmodule
